// ==== rtl/flash_protect_status.sv ====
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module flash_protect_status (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Register port.
    input flash_guard_pkg::reg_req_t req,
    output logic [flash_guard_pkg::DATA_W-1:0] rd_data,
    // Mode strap from a pin.
    input wire logic special_mode_pin,
    // Events from the command engine.
    input flash_guard_pkg::engine_evt_t evt,
    // Commands to the engine.
    output logic cmd_launch,
    output logic [flash_guard_pkg::BANK_W-1:0] launch_bank,
    output logic cmd_discard,
    output logic [flash_guard_pkg::NUM_BANKS-1:0][7:0] prot_cfg_reg,
    // Interrupt request.
    output logic irq
);

    localparam int NB = flash_guard_pkg::NUM_BANKS;

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    flash_guard_pkg::seq_state_t seq_state;
    logic [flash_guard_pkg::BANK_W-1:0] seq_bank;
    logic [flash_guard_pkg::BANK_W-1:0] bank_sel;
    logic buf_empty_irq_en;
    logic cmd_done_irq_en;
    logic buf_empty_flag;
    logic cmd_done_flag;
    logic next_buf_empty;
    logic special_meta;
    logic special_mode;
    logic [NB-1:0] prot_viol_flag;
    logic [NB-1:0] access_err_flag;
    logic [NB-1:0] fail_flag;
    logic [NB-1:0] blank_flag;
    logic [NB-1:0] set_prot_viol_flag;
    logic [NB-1:0] set_access_err_flag;
    logic [NB-1:0] set_fail;
    logic [NB-1:0] set_blank;
    logic [NB-1:0] clr_prot_viol_flag;
    logic [NB-1:0] clr_access_err_flag;
    logic [NB-1:0] clr_fail;
    logic [NB-1:0] clr_blank;
    logic wr_bank;
    logic wr_cfg;
    logic wr_prot;
    logic wr_stat;
    logic be_wr1;
    logic be_wr0;
    logic in_seq;
    logic any_err;
    logic seq_start;
    logic abort0;
    logic stray1;
    logic seq_err;
    logic launch_ok;
    logic discard;
    logic [7:0] status_byte;

    ////////////////////////////////////////////////////////////////////////
    // Helpers for the protection register.
    function automatic logic [2:0] scenario(input logic [7:0] v);
        scenario = {v[flash_guard_pkg::PROT_POL],
                    v[flash_guard_pkg::PROT_HI_OFF],
                    v[flash_guard_pkg::PROT_LO_OFF]};
    endfunction : scenario

    function automatic logic [7:0] prot_merge(input logic [7:0] cur,
                                              input logic [7:0] req_v);
        logic [7:0] m;
        m = cur;
        m[flash_guard_pkg::PROT_POL] = req_v[flash_guard_pkg::PROT_POL];
        m[flash_guard_pkg::PROT_HI_OFF] = req_v[flash_guard_pkg::PROT_HI_OFF];
        m[flash_guard_pkg::PROT_LO_OFF] = req_v[flash_guard_pkg::PROT_LO_OFF];
        if (cur[flash_guard_pkg::PROT_HI_OFF]) begin
            m[4:3] = req_v[4:3];
        end
        if (cur[flash_guard_pkg::PROT_LO_OFF]) begin
            m[1:0] = req_v[1:0];
        end
        prot_merge = m;
    endfunction : prot_merge

    ////////////////////////////////////////////////////////////////////////
    // Address decode of writes.
    always_comb begin
        wr_bank = 1'b0;
        wr_cfg = 1'b0;
        wr_prot = 1'b0;
        wr_stat = 1'b0;
        if (!req.wr) begin
            wr_bank = 1'b0;
        end else if (req.addr == flash_guard_pkg::OFS_BANK) begin
            wr_bank = 1'b1;
        end else if (req.addr == flash_guard_pkg::OFS_CFG) begin
            wr_cfg = 1'b1;
        end else if (req.addr == flash_guard_pkg::OFS_PROT) begin
            wr_prot = 1'b1;
        end else if (req.addr == flash_guard_pkg::OFS_STAT) begin
            wr_stat = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command sequence tracking.
    assign be_wr1 = wr_stat && req.wdata[flash_guard_pkg::ST_BUF_EMPTY];
    assign be_wr0 = wr_stat && !req.wdata[flash_guard_pkg::ST_BUF_EMPTY];
    assign in_seq = seq_state != flash_guard_pkg::SEQ_IDLE;
    assign any_err = |prot_viol_flag || |access_err_flag;
    assign seq_start = evt.array_write && !in_seq && buf_empty_flag
                       && !any_err;
    assign abort0 = be_wr0 && in_seq;
    assign stray1 = be_wr1 && seq_state == flash_guard_pkg::SEQ_ARRAY;
    assign seq_err = in_seq && (abort0 || stray1 || evt.seq_viol);
    assign launch_ok = be_wr1 && seq_state == flash_guard_pkg::SEQ_CMD
                       && !any_err && !fail_flag[seq_bank];
    assign discard = evt.op_err && !buf_empty_flag;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seq_state <= flash_guard_pkg::SEQ_IDLE;
            seq_bank <= flash_guard_pkg::RST_BANK;
        end else begin
            case (seq_state)
                flash_guard_pkg::SEQ_IDLE: begin
                    if (seq_start) begin
                        seq_state <= flash_guard_pkg::SEQ_ARRAY;
                        seq_bank <= evt.bank;
                    end
                end
                flash_guard_pkg::SEQ_ARRAY: begin
                    if (seq_err || evt.prot_hit) begin
                        seq_state <= flash_guard_pkg::SEQ_IDLE;
                    end else if (evt.cmd_write) begin
                        seq_state <= evt.cmd_illegal
                                     ? flash_guard_pkg::SEQ_IDLE
                                     : flash_guard_pkg::SEQ_CMD;
                    end
                end
                flash_guard_pkg::SEQ_CMD: begin
                    if (seq_err || evt.prot_hit || launch_ok) begin
                        seq_state <= flash_guard_pkg::SEQ_IDLE;
                    end
                end
                default: begin
                    seq_state <= flash_guard_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared buffer flags.
    always_comb begin
        next_buf_empty = buf_empty_flag;
        if (launch_ok) begin
            next_buf_empty = 1'b0;
        end else if (evt.buf_taken || discard) begin
            next_buf_empty = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            buf_empty_flag <= flash_guard_pkg::RST_BUF_EMPTY;
        end else begin
            buf_empty_flag <= next_buf_empty;
        end
    end

    // Command-done follows the buffer flag down and rises only on full idle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd_done_flag <= flash_guard_pkg::RST_CMD_DONE;
        end else if (!next_buf_empty) begin
            cmd_done_flag <= 1'b0;
        end else if (evt.all_done) begin
            cmd_done_flag <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd_launch <= 1'b0;
            launch_bank <= flash_guard_pkg::RST_BANK;
            cmd_discard <= 1'b0;
        end else begin
            cmd_launch <= launch_ok;
            launch_bank <= seq_bank;
            cmd_discard <= discard;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-bank status flags.
    for (genvar b = 0; b < NB; b++) begin : g_bank
        localparam int BI = b;
        logic own_sw;
        logic own_evt;
        logic own_seq;
        assign own_sw = wr_stat && bank_sel == BI[flash_guard_pkg::BANK_W-1:0];
        assign own_evt = evt.bank == BI[flash_guard_pkg::BANK_W-1:0];
        assign own_seq = seq_bank == BI[flash_guard_pkg::BANK_W-1:0];
        assign set_prot_viol_flag[b] = evt.prot_hit && own_evt;
        assign set_access_err_flag[b] = (seq_err && own_seq)
            || (own_evt && ((evt.cmd_write && evt.cmd_illegal)
            || evt.abort_erase || evt.op_err
            || (evt.cpu_stop && !cmd_done_flag)));
        assign set_fail[b] = evt.verify_done && !evt.verify_blank
                             && own_evt;
        assign set_blank[b] = evt.verify_done && evt.verify_blank
                              && own_evt;
        assign clr_prot_viol_flag[b] = own_sw
                              && req.wdata[flash_guard_pkg::ST_PROT_VIOL];
        assign clr_access_err_flag[b] = own_sw
                               && req.wdata[flash_guard_pkg::ST_ACC_ERR];
        assign clr_fail[b] = own_sw && special_mode
                             && req.wdata[flash_guard_pkg::ST_FAIL];
        assign clr_blank[b] = launch_ok && own_seq;

        flag_bit #(.RESET_VAL(flash_guard_pkg::RST_FLAG)) u_prot_viol_flag (
            .clk(clk), .nrst(nrst), .set(set_prot_viol_flag[b]),
            .clr(clr_prot_viol_flag[b]), .q(prot_viol_flag[b])
        );
        flag_bit #(.RESET_VAL(flash_guard_pkg::RST_FLAG)) u_access_err_flag (
            .clk(clk), .nrst(nrst), .set(set_access_err_flag[b]),
            .clr(clr_access_err_flag[b]), .q(access_err_flag[b])
        );
        flag_bit #(.RESET_VAL(flash_guard_pkg::RST_FLAG)) u_fail (
            .clk(clk), .nrst(nrst), .set(set_fail[b]),
            .clr(clr_fail[b]), .q(fail_flag[b])
        );
        flag_bit #(.RESET_VAL(flash_guard_pkg::RST_FLAG)) u_blank (
            .clk(clk), .nrst(nrst), .set(set_blank[b]),
            .clr(clr_blank[b]), .q(blank_flag[b])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Protection registers, one per bank.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prot_cfg_reg <= {NB{flash_guard_pkg::RST_PROT}};
        end else begin
            for (int b = 0; b < NB; b++) begin
                if (evt.prot_load
                    && evt.bank == b[flash_guard_pkg::BANK_W-1:0]) begin
                    prot_cfg_reg[b] <= evt.prot_value;
                end else if (wr_prot
                    && bank_sel == b[flash_guard_pkg::BANK_W-1:0]
                    && flash_guard_pkg::SCEN_ALLOWED
                       [scenario(prot_cfg_reg[b])]
                       [scenario(req.wdata)]) begin
                    prot_cfg_reg[b] <= prot_merge(prot_cfg_reg[b],
                                                  req.wdata);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration, bank select and mode strap.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            buf_empty_irq_en <= flash_guard_pkg::RST_BE_IE;
            cmd_done_irq_en <= flash_guard_pkg::RST_CD_IE;
        end else if (wr_cfg) begin
            buf_empty_irq_en <= req.wdata[flash_guard_pkg::CFG_BE_IE];
            cmd_done_irq_en <= req.wdata[flash_guard_pkg::CFG_CD_IE];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bank_sel <= flash_guard_pkg::RST_BANK;
        end else if (wr_bank) begin
            bank_sel <= req.wdata[flash_guard_pkg::BANK_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            special_meta <= 1'b0;
            special_mode <= 1'b0;
        end else begin
            special_meta <= special_mode_pin;
            special_mode <= special_meta;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= (buf_empty_flag && buf_empty_irq_en)
                   || (cmd_done_flag && cmd_done_irq_en);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path.
    always_comb begin
        status_byte = 8'h00;
        status_byte[flash_guard_pkg::ST_BUF_EMPTY] = buf_empty_flag;
        status_byte[flash_guard_pkg::ST_CMD_DONE] = cmd_done_flag;
        status_byte[flash_guard_pkg::ST_PROT_VIOL] = prot_viol_flag[bank_sel];
        status_byte[flash_guard_pkg::ST_ACC_ERR] = access_err_flag[bank_sel];
        status_byte[flash_guard_pkg::ST_BLANK] = blank_flag[bank_sel];
        status_byte[flash_guard_pkg::ST_FAIL] = fail_flag[bank_sel];
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= 8'h00;
        end else if (!req.rd) begin
            rd_data <= 8'h00;
        end else if (req.addr == flash_guard_pkg::OFS_BANK) begin
            rd_data <= {{(8 - flash_guard_pkg::BANK_W){1'b0}}, bank_sel};
        end else if (req.addr == flash_guard_pkg::OFS_CFG) begin
            rd_data <= {buf_empty_irq_en, cmd_done_irq_en, 6'h00};
        end else if (req.addr == flash_guard_pkg::OFS_PROT) begin
            rd_data <= prot_cfg_reg[bank_sel];
        end else if (req.addr == flash_guard_pkg::OFS_STAT) begin
            rd_data <= status_byte;
        end else begin
            rd_data <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_prot_refused;
        wr_prot && !evt.prot_load && !flash_guard_pkg::SCEN_ALLOWED
            [scenario(prot_cfg_reg[bank_sel])][scenario(req.wdata)]
        |=> $stable(prot_cfg_reg);
    endproperty
    a_prot_refused: assert property (p_prot_refused)
        else $error("Forbidden protection write changed the register.");

    property p_prot_move;
        wr_prot && !evt.prot_load && bank_sel == 1'b0
        |=> flash_guard_pkg::SCEN_ALLOWED[scenario($past(prot_cfg_reg[0]))]
            [scenario(prot_cfg_reg[0])];
    endproperty
    a_prot_move: assert property (p_prot_move)
        else $error("Protection moved to a scenario not allowed.");

    property p_prot_read;
        req.rd && req.addr == flash_guard_pkg::OFS_PROT && !wr_prot
        |=> rd_data == $past(prot_cfg_reg[bank_sel]);
    endproperty
    a_prot_read: assert property (p_prot_read)
        else $error("Protection read does not show the register.");

    property p_abort;
        abort0 && seq_bank == 1'b0 |=> access_err_flag[0]
            && seq_state == flash_guard_pkg::SEQ_IDLE ##1 !cmd_launch;
    endproperty
    a_abort: assert property (p_abort)
        else $error("Zero write into buffer-empty did not abort.");

    property p_irq;
        ##1 irq == ($past(buf_empty_flag) && $past(buf_empty_irq_en)
                    || $past(cmd_done_flag) && $past(cmd_done_irq_en));
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt does not follow flags and enables.");

    property p_done_low;
        !buf_empty_flag |-> !cmd_done_flag;
    endproperty
    a_done_low: assert property (p_done_low)
        else $error("Command-done set while buffer-empty is clear.");

    property p_block;
        cmd_launch |-> $past(!any_err) && !$past(fail_flag[seq_bank]);
    endproperty
    a_block: assert property (p_block)
        else $error("Command launched while an error flag was set.");

    property p_discard;
        evt.op_err && !buf_empty_flag |=> buf_empty_flag && cmd_discard
            && !cmd_launch;
    endproperty
    a_discard: assert property (p_discard)
        else $error("Buffered command not discarded on operation error.");

    property p_fail_normal;
        !special_mode && !set_fail[0] |=> fail_flag[0] || !$past(fail_flag[0]);
    endproperty
    a_fail_normal: assert property (p_fail_normal)
        else $error("Fail flag cleared outside special mode.");

    c_launch: cover property (seq_start ##[1:20] cmd_launch);
    c_abort: cover property (abort0);
    c_prot_change: cover property (wr_prot ##1 $changed(prot_cfg_reg));
    c_discard: cover property (discard);

endmodule : flash_protect_status

// ==== rtl/flash_guard_pkg.sv ====
package flash_guard_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes.
    localparam int NUM_BANKS = 2;
    localparam int BANK_W = 1;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets.
    localparam logic [ADDR_W-1:0] OFS_BANK = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CFG = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_PROT = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STAT = 4'h5;

    ////////////////////////////////////////////////////////////////////////
    // Status register fields.
    localparam int ST_BUF_EMPTY = 7;
    localparam int ST_CMD_DONE = 6;
    localparam int ST_PROT_VIOL = 5;
    localparam int ST_ACC_ERR = 4;
    localparam int ST_BLANK = 2;
    localparam int ST_FAIL = 1;

    // Configuration register fields.
    localparam int CFG_BE_IE = 7;
    localparam int CFG_CD_IE = 6;

    // Protection register fields.
    localparam int PROT_POL = 7;
    localparam int PROT_HI_OFF = 5;
    localparam int PROT_HI_SZ_MSB = 4;
    localparam int PROT_HI_SZ_LSB = 3;
    localparam int PROT_LO_OFF = 2;
    localparam int PROT_LO_SZ_MSB = 1;
    localparam int PROT_LO_SZ_LSB = 0;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic [DATA_W-1:0] RST_PROT = 8'hFF;
    localparam logic RST_BE_IE = 1'b0;
    localparam logic RST_CD_IE = 1'b0;
    localparam logic [BANK_W-1:0] RST_BANK = 1'h0;
    localparam logic RST_BUF_EMPTY = 1'b1;
    localparam logic RST_CMD_DONE = 1'b1;
    localparam logic RST_FLAG = 1'b0;

    // Row is the scenario in force, bit is the scenario requested.
    localparam logic [7:0][7:0] SCEN_ALLOWED = {
        8'hFF, 8'h5A, 8'h3C, 8'h18, 8'h08, 8'h0C, 8'h0A, 8'h0F
    };

    ////////////////////////////////////////////////////////////////////////
    // Types.
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ARRAY = 2'b01,
        SEQ_CMD = 2'b11
    } seq_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [BANK_W-1:0] bank;
        logic array_write;
        logic cmd_write;
        logic cmd_illegal;
        logic seq_viol;
        logic prot_hit;
        logic abort_erase;
        logic cpu_stop;
        logic buf_taken;
        logic all_done;
        logic verify_done;
        logic verify_blank;
        logic op_err;
        logic prot_load;
        logic [DATA_W-1:0] prot_value;
    } engine_evt_t;

endpackage : flash_guard_pkg

// ==== rtl/flag_bit.sv ====
`timescale 1ns/1ps
module flag_bit #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Set and clear requests; a set in the clearing cycle wins.
    input wire logic set,
    input wire logic clr,
    // Flag.
    output logic q
);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= RESET_VAL;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end

endmodule : flag_bit

// ==== tb/flash_protect_status_tb.sv ====
`timescale 1ns/1ps
module flash_protect_status_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    flash_guard_pkg::reg_req_t req = '0;
    logic special_mode_pin = 1'b0;
    flash_guard_pkg::engine_evt_t evt = '0;
    logic [7:0] rd_data;
    logic cmd_launch;
    logic cmd_discard;
    logic irq;
    logic [flash_guard_pkg::BANK_W-1:0] launch_bank;
    logic [flash_guard_pkg::NUM_BANKS-1:0][7:0] prot_cfg_reg;
    logic [7:0] exp_q[$];
    logic rd_pend = 1'b0;
    int fails = 0;
    int checked = 0;
    logic [7:0] allow [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08,
                              8'h18, 8'h3C, 8'h5A, 8'hFF};
    logic [7:0] cur, w, e;
    localparam logic [3:0] ST = flash_guard_pkg::OFS_STAT;

    always #50 clk = ~clk;

    flash_protect_status uut (.clk(clk), .nrst(nrst), .req(req),
        .rd_data(rd_data), .special_mode_pin(special_mode_pin), .evt(evt),
        .cmd_launch(cmd_launch), .launch_bank(launch_bank),
        .cmd_discard(cmd_discard), .prot_cfg_reg(prot_cfg_reg), .irq(irq));

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task close_out;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    // Queues the expected value; the monitor compares when data stands.
    task rd(input logic [3:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
    endtask : rd

    task ev(input flash_guard_pkg::engine_evt_t x);
        @(posedge clk);
        evt <= x;
        @(posedge clk);
        evt <= '0;
    endtask : ev

    task launch(input logic [7:0] st);
        ev('{array_write: 1'b1, default: '0});
        ev('{cmd_write: 1'b1, default: '0});
        wr(ST, st);
        @(posedge clk);
    endtask : launch

    task err(input flash_guard_pkg::engine_evt_t x, input logic [7:0] s);
        ev(x);
        rd(ST, s);
        wr(ST, 8'h10);
    endtask : err

    always @(posedge clk) begin
        if (rd_pend) chk(rd_data, exp_q.pop_front());
        rd_pend <= req.rd;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(24844));
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(ST, 8'hC0);
        rd(flash_guard_pkg::OFS_PROT, 8'hFF);
        rd(4'h9, 8'h00);
        wr(ST, 8'h4E);
        rd(ST, 8'hC0);
        for (int s = 0; s < 8; s++) begin
            for (int t = 0; t < 8; t++) begin
                cur = $urandom;
                cur[7] = s[2]; cur[5] = s[1]; cur[2] = s[0];
                ev('{prot_load: 1'b1, prot_value: cur, default: '0});
                w = $urandom;
                w[7] = t[2]; w[5] = t[1]; w[2] = t[0];
                e = cur;
                if (allow[s][t]) begin
                    e[7] = w[7]; e[5] = w[5]; e[2] = w[2];
                    if (cur[5]) e[4:3] = w[4:3];
                    if (cur[2]) e[1:0] = w[1:0];
                end
                wr(flash_guard_pkg::OFS_PROT, w);
                rd(flash_guard_pkg::OFS_PROT, e);
                chk(prot_cfg_reg[0], e);
            end
        end
        wr(flash_guard_pkg::OFS_CFG, 8'h80);
        repeat (2) @(posedge clk);
        chk({7'd0, irq}, 8'h01);
        launch(8'h80);
        chk({7'd0, cmd_launch}, 8'h01);
        rd(ST, 8'h00);
        chk({7'd0, irq}, 8'h00);
        ev('{buf_taken: 1'b1, default: '0});
        rd(ST, 8'h80);
        wr(flash_guard_pkg::OFS_CFG, 8'h40);
        ev('{all_done: 1'b1, default: '0});
        rd(ST, 8'hC0);
        chk({7'd0, irq}, 8'h01);
        ev('{array_write: 1'b1, default: '0});
        wr(ST, 8'h00);
        rd(ST, 8'hD0);
        launch(8'h80);
        chk({7'd0, cmd_launch}, 8'h00);
        wr(ST, 8'h00);
        rd(ST, 8'hD0);
        wr(ST, 8'h10);
        ev('{prot_hit: 1'b1, bank: 1'b1, default: '0});
        launch(8'h80);
        chk({7'd0, cmd_launch}, 8'h00);
        wr(flash_guard_pkg::OFS_BANK, 8'h01);
        rd(ST, 8'hE0);
        wr(ST, 8'h20);
        rd(ST, 8'hC0);
        wr(flash_guard_pkg::OFS_BANK, 8'h00);
        err('{abort_erase: 1'b1, default: '0}, 8'hD0);
        err('{cmd_write: 1'b1, cmd_illegal: 1'b1, default: '0}, 8'hD0);
        ev('{array_write: 1'b1, default: '0});
        err('{seq_viol: 1'b1, default: '0}, 8'hD0);
        err('{cpu_stop: 1'b1, default: '0}, 8'hC0);
        ev('{array_write: 1'b1, default: '0});
        ev('{cmd_write: 1'b1, default: '0});
        ev('{verify_done: 1'b1, default: '0});
        rd(ST, 8'hC2);
        wr(ST, 8'h80);
        @(posedge clk);
        chk({7'd0, cmd_launch}, 8'h00);
        wr(ST, 8'h82);
        rd(ST, 8'hC2);
        special_mode_pin <= 1'b1;
        repeat (3) @(posedge clk);
        wr(ST, 8'h82);
        rd(ST, 8'hC0);
        wr(ST, 8'h80);
        @(posedge clk);
        chk({7'd0, cmd_launch}, 8'h01);
        chk({7'd0, launch_bank}, 8'h00);
        ev('{op_err: 1'b1, default: '0});
        @(posedge clk);
        chk({7'd0, cmd_discard}, 8'h01);
        rd(ST, 8'h90);
        ev('{all_done: 1'b1, default: '0});
        wr(ST, 8'h10);
        ev('{verify_done: 1'b1, verify_blank: 1'b1, default: '0});
        wr(ST, 8'h04);
        rd(ST, 8'hC4);
        launch(8'h80);
        ev('{buf_taken: 1'b1, default: '0});
        ev('{all_done: 1'b1, default: '0});
        rd(ST, 8'hC0);
        repeat (3) @(posedge clk);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out();
    end
endmodule : flash_protect_status_tb
